// ### verilog/dcf_pkg.sv
// dcf_pkg: constants for the dual-clock fifo control block
// assumes: one system clock; write and read clocks sampled as data
//
// Behaviour
// - master clear resets pointers and flag levels
// - master clear latches standard or fall-through mode
// - access low at clear: 07FH defaults, parallel load
// - access high at clear: 3FFH defaults, serial load
// - clear zeroes output register, acts asynchronously
// - partial clear resets pointers, keeps mode
// - partial clear keeps offsets, method; zeroes output
// - replay low on read edge rewinds read pointer
// - standard replay: empty low, then high; reads enabled
// - fall-through replay: valid high, then first word
// - serial input loads offsets only when serial chosen
// - fall-through first word appears after three read edges
// - write edges update full, almost full; lower half
// - write enable low stores word unless full
// - full releases two write edges after a read
// - read edges update empty, almost empty; raise half
// - read enable low loads next word unless empty
// - standard empty low after last read, high later
// - fall-through valid high on true read when empty
// - serial enable and access low shift one bit
// - access low redirects transfers to offset registers
// - drive enable low raises o_dout_oe a clock later, else lowers it
`default_nettype none

package dcf_pkg;

  // ==========================================================
  // geometry
  localparam int DCF_DW = 18;
  localparam int DCF_AW = 13;
  localparam int DCF_PW = 14;
  localparam int DCF_OW = 13;

  localparam logic [DCF_PW-1:0] DCF_DEPTH     = 14'h2000;
  localparam logic [DCF_PW-1:0] DCF_HALF      = 14'h1000;
  localparam logic [DCF_PW-1:0] DCF_PTR_FIRST = 14'h0000;
  localparam logic [DCF_PW-1:0] DCF_PTR_STEP  = 14'h0001;

  // ==========================================================
  // reset values
  localparam logic [DCF_OW-1:0] DCF_OFS_PAR_DEF = 13'h007F;
  localparam logic [DCF_OW-1:0] DCF_OFS_SER_DEF = 13'h03FF;
  localparam logic [DCF_DW-1:0] DCF_DOUT_CLR    = 18'h00000;

  // ==========================================================
  // offset register selector
  typedef enum logic {
    DCF_SEL_EMPTY,
    DCF_SEL_FULL
  } dcf_ofs_sel_type;

endpackage : dcf_pkg

`default_nettype wire

// ### verilog/dcf_gray_sync.sv
// dcf_gray_sync: two-stage carrier of a gray pointer into a domain
// assumes: i_en is the one-cycle edge pulse of the receiving domain
`timescale 1ns/1ps
`default_nettype none

module dcf_gray_sync
  import dcf_pkg::*;
#(
  parameter int W = DCF_PW
) (
  // clock and clear
  input  wire logic         i_clk,
  input  wire logic         i_clr_n,
  // receiving domain edge
  input  wire logic         i_en,
  // pointers
  input  wire logic [W-1:0] i_gray,
  output logic      [W-1:0] o_gray
);

  // ==========================================================
  // stages
  logic [W-1:0] s1_q;

  always_ff @(posedge i_clk or negedge i_clr_n) begin
    if (!i_clr_n) begin
      s1_q <= '0;
    end else begin
      s1_q <= i_gray;
    end
  end

  always_ff @(posedge i_clk or negedge i_clr_n) begin
    if (!i_clr_n) begin
      o_gray <= '0;
    end else if (i_en) begin
      o_gray <= s1_q;
    end
  end

endmodule : dcf_gray_sync

`default_nettype wire

// ### verilog/dcf_fifo_ctrl.sv
// dcf_fifo_ctrl: deep 18-bit fifo with write and read ports
// assumes: write/read clocks arrive as data sampled on i_clk,
// each high and low for at least one i_clk period
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo_ctrl
  import dcf_pkg::*;
(
  // system
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // clears
  input  wire logic              i_master_clear_n,
  input  wire logic              i_partial_clear_n,
  // write port
  input  wire logic              i_wr_clk,
  input  wire logic              i_wr_en_n,
  input  wire logic [DCF_DW-1:0] i_din,
  // read port
  input  wire logic              i_rd_clk,
  input  wire logic              i_rd_en_n,
  input  wire logic              i_replay_n,
  input  wire logic              i_out_drive_en_n,
  // offset programming
  input  wire logic              i_offset_access_n,
  input  wire logic              i_ser_load_en_n,
  input  wire logic              i_fallthrough_serial_in,
  // data out
  output logic      [DCF_DW-1:0] o_dout,
  output logic                   o_dout_oe,
  // flags
  output logic                   o_full_space_n,
  output logic                   o_empty_valid_n,
  output logic                   o_almost_full_n,
  output logic                   o_almost_empty_n,
  output logic                   o_half_full_n
);

  // ==========================================================
  // declarations
  logic                  wclk_q;
  logic                  rclk_q;
  logic                  we;
  logic                  re;
  logic                  clr_n;
  logic                  clr;
  logic                  fall_through_mode_q;
  logic                  serial_q;
  logic [DCF_OW-1:0]     ofs_empty_q;
  logic [DCF_OW-1:0]     ofs_full_q;
  dcf_ofs_sel_type       pw_sel_q;
  dcf_ofs_sel_type       pr_sel_q;
  logic [DCF_DW-1:0]     mem [0:(1<<DCF_AW)-1];
  logic [DCF_PW-1:0]     wptr_q;
  logic [DCF_PW-1:0]     wptr_d;
  logic [DCF_PW-1:0]     wgray;
  logic [DCF_PW-1:0]     rgray_w;
  logic [DCF_PW-1:0]     rbin_w;
  logic [DCF_PW-1:0]     wcount_d;
  logic                  full_q;
  logic                  full_d;
  logic                  wr_take;
  logic [DCF_PW-1:0]     rptr_q;
  logic [DCF_PW-1:0]     rptr_d;
  logic [DCF_PW-1:0]     rgray;
  logic [DCF_PW-1:0]     wgray_r;
  logic [DCF_PW-1:0]     wbin_r;
  logic [DCF_PW-1:0]     rcount_d;
  logic [DCF_PW-1:0]     hcount;
  logic                  avail_q;
  logic                  avail_d;
  logic                  ov_q;
  logic                  ov_d;
  logic                  replay;
  logic                  std_read;
  logic                  fw_load;
  logic                  fw_drop;
  logic                  pop;
  logic                  ofs_read;
  logic [DCF_DW-1:0]     ofs_word;

  // ==========================================================
  // gray conversion
  function automatic logic [DCF_PW-1:0] gray2bin(input logic [DCF_PW-1:0] g);
    logic [DCF_PW-1:0] b;
    b = '0;
    b[DCF_PW-1] = g[DCF_PW-1];
    for (int i = DCF_PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  // ==========================================================
  // port clock edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
    end else begin
      wclk_q <= i_wr_clk;
      rclk_q <= i_rd_clk;
    end
  end

  // stopped clocks give no edges, so flags hold
  assign we = i_wr_clk & ~wclk_q;
  assign re = i_rd_clk & ~rclk_q;

  // both clears reach the pointer state without the clock
  assign clr_n = i_rst_n & i_master_clear_n & i_partial_clear_n;
  assign clr   = ~(i_master_clear_n & i_partial_clear_n);

  // ==========================================================
  // mode and method, caught during master clear only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fall_through_mode_q   <= 1'b0;
      serial_q <= 1'b0;
    end else if (!i_master_clear_n) begin
      fall_through_mode_q   <= i_fallthrough_serial_in;
      serial_q <= i_offset_access_n;
    end
  end

  // ==========================================================
  // offset registers, untouched by partial clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ofs_empty_q <= DCF_OFS_SER_DEF;
      ofs_full_q  <= DCF_OFS_SER_DEF;
      pw_sel_q    <= DCF_SEL_EMPTY;
    end else if (!i_master_clear_n) begin
      pw_sel_q <= DCF_SEL_EMPTY;
      if (i_offset_access_n) begin
        ofs_empty_q <= DCF_OFS_SER_DEF;
        ofs_full_q  <= DCF_OFS_SER_DEF;
      end else begin
        ofs_empty_q <= DCF_OFS_PAR_DEF;
        ofs_full_q  <= DCF_OFS_PAR_DEF;
      end
    end else if (we && !i_offset_access_n) begin
      if (serial_q && !i_ser_load_en_n) begin
        {ofs_full_q, ofs_empty_q} <=
          {i_fallthrough_serial_in, ofs_full_q, ofs_empty_q[DCF_OW-1:1]};
      end else if (!serial_q && !i_wr_en_n) begin
        if (pw_sel_q == DCF_SEL_EMPTY) begin
          ofs_empty_q <= i_din[DCF_OW-1:0];
          pw_sel_q    <= DCF_SEL_FULL;
        end else begin
          ofs_full_q <= i_din[DCF_OW-1:0];
          pw_sel_q   <= DCF_SEL_EMPTY;
        end
      end
    end
  end

  // ==========================================================
  // pointer crossings
  assign wgray = wptr_q ^ (wptr_q >> 1);
  assign rgray = rptr_q ^ (rptr_q >> 1);

  dcf_gray_sync #(
    .W(DCF_PW)
  ) u_wr_to_rd (
    .i_clk   (i_clk),
    .i_clr_n (clr_n),
    .i_en    (re),
    .i_gray  (wgray),
    .o_gray  (wgray_r)
  );

  dcf_gray_sync #(
    .W(DCF_PW)
  ) u_rd_to_wr (
    .i_clk   (i_clk),
    .i_clr_n (clr_n),
    .i_en    (we),
    .i_gray  (rgray),
    .o_gray  (rgray_w)
  );

  assign rbin_w = gray2bin(rgray_w);
  assign wbin_r = gray2bin(wgray_r);

  // ==========================================================
  // write side
  assign wr_take  = we & ~i_wr_en_n & i_offset_access_n & ~full_q;
  assign wptr_d   = wr_take ? wptr_q + DCF_PTR_STEP : wptr_q;
  assign wcount_d = wptr_d - rbin_w;
  assign full_d   = (wcount_d == DCF_DEPTH);

  always_ff @(posedge i_clk) begin
    if (wr_take) begin
      mem[wptr_q[DCF_AW-1:0]] <= i_din;
    end
  end

  always_ff @(posedge i_clk or negedge clr_n) begin
    if (!clr_n) begin
      wptr_q <= DCF_PTR_FIRST;
      full_q <= 1'b0;
    end else if (we) begin
      wptr_q <= wptr_d;
      full_q <= full_d;
    end
  end

  // ==========================================================
  // read side
  assign replay   = re & ~i_replay_n;
  assign ofs_read = re & ~i_offset_access_n & ~i_rd_en_n & i_replay_n;
  assign std_read = re & ~fall_through_mode_q & i_offset_access_n & ~i_rd_en_n & avail_q;
  assign fw_load  = re & fall_through_mode_q & i_offset_access_n & avail_q
                    & (~ov_q | ~i_rd_en_n);
  assign fw_drop  = re & fall_through_mode_q & i_offset_access_n & ov_q
                    & ~i_rd_en_n & ~avail_q;
  assign pop      = (std_read | fw_load) & ~replay;
  assign ofs_word = {{(DCF_DW-DCF_OW){1'b0}},
                     (pr_sel_q == DCF_SEL_EMPTY) ? ofs_empty_q : ofs_full_q};

  always_comb begin
    if (replay) begin
      rptr_d = DCF_PTR_FIRST;
    end else if (pop) begin
      rptr_d = rptr_q + DCF_PTR_STEP;
    end else begin
      rptr_d = rptr_q;
    end
    avail_d  = ~replay & (rptr_d != wbin_r);
    rcount_d = wbin_r - rptr_d;
    if (replay) begin
      ov_d = 1'b0;
    end else if (fw_load) begin
      ov_d = 1'b1;
    end else if (fw_drop) begin
      ov_d = 1'b0;
    end else begin
      ov_d = ov_q;
    end
  end

  always_ff @(posedge i_clk or negedge clr_n) begin
    if (!clr_n) begin
      rptr_q  <= DCF_PTR_FIRST;
      avail_q <= 1'b0;
      ov_q    <= 1'b0;
    end else if (re) begin
      rptr_q  <= rptr_d;
      avail_q <= avail_d;
      ov_q    <= ov_d;
    end
  end

  // output register, zeroed by either clear
  always_ff @(posedge i_clk or negedge clr_n) begin
    if (!clr_n) begin
      o_dout <= DCF_DOUT_CLR;
    end else if (ofs_read) begin
      o_dout <= ofs_word;
    end else if (pop) begin
      o_dout <= mem[rptr_q[DCF_AW-1:0]];
    end
  end

  // parallel offset read selector, kept over partial clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pr_sel_q <= DCF_SEL_EMPTY;
    end else if (!i_master_clear_n) begin
      pr_sel_q <= DCF_SEL_EMPTY;
    end else if (ofs_read) begin
      pr_sel_q <= (pr_sel_q == DCF_SEL_EMPTY) ? DCF_SEL_FULL : DCF_SEL_EMPTY;
    end
  end

  // ==========================================================
  // output drive
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dout_oe <= 1'b0;
    end else begin
      o_dout_oe <= ~i_out_drive_en_n;
    end
  end

  // ==========================================================
  // write-side flags
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_full_space_n  <= 1'b1;
      o_almost_full_n <= 1'b1;
    end else if (clr) begin
      o_full_space_n  <= ~fall_through_mode_q;
      o_almost_full_n <= 1'b1;
    end else if (we) begin
      o_full_space_n  <= full_d ^ ~fall_through_mode_q;
      o_almost_full_n <= ~(wcount_d >= (DCF_DEPTH - {1'b0, ofs_full_q}));
    end
  end

  // ==========================================================
  // read-side flags
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_empty_valid_n  <= 1'b0;
      o_almost_empty_n <= 1'b0;
    end else if (clr) begin
      o_empty_valid_n  <= fall_through_mode_q;
      o_almost_empty_n <= 1'b0;
    end else if (re) begin
      if (fall_through_mode_q) begin
        o_empty_valid_n <= ~ov_d;
      end else begin
        o_empty_valid_n <= avail_d;
      end
      o_almost_empty_n <= ~(rcount_d <= {1'b0, ofs_empty_q});
    end
  end

  // ==========================================================
  // half full: write edges lower it, read edges raise it
  // live pointer gap: a stale synchronised copy would raise it early
  assign hcount = wptr_d - rptr_d;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_half_full_n <= 1'b1;
    end else if (clr) begin
      o_half_full_n <= 1'b1;
    end else if (we && (hcount > DCF_HALF)) begin
      o_half_full_n <= 1'b0;
    end else if (re && (hcount <= DCF_HALF)) begin
      o_half_full_n <= 1'b1;
    end
  end

endmodule : dcf_fifo_ctrl

`default_nettype wire

// ### verif/dcf_fifo_ctrl_assertions.sv
// dcf_fifo_ctrl_assertions: port checks of the fifo control block
// assumes: bound into dcf_fifo_ctrl, port clocks sampled on i_clk
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo_ctrl_chk
  import dcf_pkg::*;
(
  // system and controls
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_master_clear_n,
  input wire logic              i_partial_clear_n,
  input wire logic              i_wr_clk,
  input wire logic              i_rd_clk,
  input wire logic              i_out_drive_en_n,
  input wire logic              i_fallthrough_serial_in,
  // watched outputs
  input wire logic [DCF_DW-1:0] o_dout,
  input wire logic              o_dout_oe,
  input wire logic              o_full_space_n,
  input wire logic              o_empty_valid_n,
  input wire logic              o_almost_full_n,
  input wire logic              o_almost_empty_n,
  input wire logic              o_half_full_n
);
  // ====
  // port edge history
  logic      wr_q, rd_q, we_q, re_q, live_q;
  wire logic clr_n = i_master_clear_n & i_partial_clear_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      we_q   <= 1'b0;
      re_q   <= 1'b0;
      live_q <= 1'b0;
    end else begin
      wr_q   <= i_wr_clk;
      rd_q   <= i_rd_clk;
      we_q   <= i_wr_clk & ~wr_q;
      re_q   <= i_rd_clk & ~rd_q;
      live_q <= 1'b1;
    end
  end

  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ====
  // properties
  property p_clr_flags;
    $past(!clr_n) |-> o_almost_full_n && !o_almost_empty_n && o_half_full_n;
  endproperty
  a_clr_flags: assert property (p_clr_flags) else $error("clear flags wrong");

  property p_mode;
    $past(live_q) && $past(!i_master_clear_n) && $past(!i_master_clear_n, 2)
      && $past(i_fallthrough_serial_in) == $past(i_fallthrough_serial_in, 2)
      |-> o_full_space_n == !$past(i_fallthrough_serial_in)
      && o_empty_valid_n == $past(i_fallthrough_serial_in);
  endproperty
  a_mode: assert property (p_mode) else $error("mode flags wrong");

  property p_dout_clr;
    !clr_n |-> o_dout == DCF_DOUT_CLR;
  endproperty
  a_dout_clr: assert property (p_dout_clr) else $error("dout not cleared");

  property p_oe;
    live_q |-> o_dout_oe == !$past(i_out_drive_en_n);
  endproperty
  a_oe: assert property (p_oe) else $error("drive enable wrong");

  property p_wr_idle;
    live_q && !we_q && $past(clr_n) |-> $stable(o_full_space_n) && $stable(o_almost_full_n);
  endproperty
  a_wr_idle: assert property (p_wr_idle) else $error("write flag moved");

  property p_rd_idle;
    live_q && !re_q && $past(clr_n) |-> $stable(o_empty_valid_n) && $stable(o_almost_empty_n);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read flag moved");

  property p_hf_fall;
    $fell(o_half_full_n) |-> we_q;
  endproperty
  a_hf_fall: assert property (p_hf_fall) else $error("half fell off write");

  property p_hf_rise;
    $rose(o_half_full_n) |-> re_q || $past(!clr_n);
  endproperty
  a_hf_rise: assert property (p_hf_rise) else $error("half rose off read");

  property p_dout_hold;
    live_q && !re_q && $past(clr_n) && clr_n |-> $stable(o_dout);
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("dout moved");
endmodule : dcf_fifo_ctrl_chk

bind dcf_fifo_ctrl dcf_fifo_ctrl_chk u_dcf_fifo_ctrl_chk (
  .i_clk, .i_rst_n, .i_master_clear_n, .i_partial_clear_n, .i_wr_clk, .i_rd_clk,
  .i_out_drive_en_n, .i_fallthrough_serial_in, .o_dout, .o_dout_oe, .o_full_space_n,
  .o_empty_valid_n, .o_almost_full_n, .o_almost_empty_n, .o_half_full_n
);

`default_nettype wire

// ### verif/dcf_port_model.sv
// dcf_port_model: writer and reader clock sources of the far side
// assumes: one-cycle go pulses from the bench on i_clk
`timescale 1ns/1ps
`default_nettype none

module dcf_port_model (
  // system
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // requests
  input  wire logic i_wr_go,
  input  wire logic i_rd_go,
  // port clocks
  output logic      o_wr_clk,
  output logic      o_rd_clk
);
  // ====
  // one high cycle per request, low while idle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wr_clk <= 1'b0;
      o_rd_clk <= 1'b0;
    end else begin
      o_wr_clk <= i_wr_go;
      o_rd_clk <= i_rd_go;
    end
  end
endmodule : dcf_port_model

`default_nettype wire

// ### verif/dcf_fifo_ctrl_tb.sv
// dcf_fifo_ctrl_tb: self-checking bench of the fifo control block
// assumes: port clocks from dcf_port_model, checker bound by its file
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo_ctrl_tb
  import dcf_pkg::*;
;
  // ====
  // signals
  logic              i_clk, i_rst_n, i_master_clear_n, i_partial_clear_n;
  logic              i_wr_clk, i_rd_clk, wr_go, rd_go, i_wr_en_n, i_rd_en_n;
  logic              i_replay_n, i_out_drive_en_n, i_offset_access_n;
  logic              i_ser_load_en_n, i_fallthrough_serial_in;
  logic [DCF_DW-1:0] i_din, o_dout;
  logic              o_dout_oe, o_full_space_n, o_empty_valid_n;
  logic              o_almost_full_n, o_almost_empty_n, o_half_full_n;
  logic [4:0]        flags;
  int                n_fail, samples_checked;
  logic [2*DCF_DW-1:0] rows [4] = '{{18'h3FFFF, 18'h3FFFF}, {18'h00000, 18'h00000},
                                    {18'h2AAAA, 18'h2AAAA}, {18'h15555, 18'h15555}};
  localparam logic [2*DCF_OW-1:0] SER_WORD = {13'h1ABC, 13'h0123};

  assign flags = {o_full_space_n, o_empty_valid_n, o_almost_full_n, o_almost_empty_n,
                  o_half_full_n};

  dcf_fifo_ctrl u_dcf_fifo_ctrl (
    .i_clk, .i_rst_n, .i_master_clear_n, .i_partial_clear_n, .i_wr_clk, .i_wr_en_n,
    .i_din, .i_rd_clk, .i_rd_en_n, .i_replay_n, .i_out_drive_en_n, .i_offset_access_n,
    .i_ser_load_en_n, .i_fallthrough_serial_in, .o_dout, .o_dout_oe, .o_full_space_n,
    .o_empty_valid_n, .o_almost_full_n, .o_almost_empty_n, .o_half_full_n
  );
  dcf_port_model u_dcf_port_model (
    .i_clk, .i_rst_n, .i_wr_go(wr_go), .i_rd_go(rd_go), .o_wr_clk(i_wr_clk),
    .o_rd_clk(i_rd_clk)
  );

  // ====
  // tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [DCF_DW-1:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic chf(input string nm, input logic exp, got);
    chk(nm, DCF_DW'(exp), DCF_DW'(got));
  endtask : chf

  task automatic port(input logic w, r, wen, ren, rt, acc, input logic [DCF_DW-1:0] d = '0);
    @(posedge i_clk);
    wr_go             <= w;
    rd_go             <= r;
    i_wr_en_n         <= wen;
    i_rd_en_n         <= ren;
    i_replay_n        <= rt;
    i_offset_access_n <= acc;
    i_din             <= d;
    @(posedge i_clk);
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : port

  task automatic mclr(input logic s, a);
    @(posedge i_clk);
    i_master_clear_n        <= 1'b0;
    i_fallthrough_serial_in <= s;
    i_offset_access_n       <= a;
    repeat (2) @(posedge i_clk);
    i_master_clear_n        <= 1'b1;
    i_fallthrough_serial_in <= 1'b0;
    i_offset_access_n       <= 1'b1;
    @(posedge i_clk);
    #1;
    chk("flags", DCF_DW'({~s, s, 3'b101}), DCF_DW'(flags));
    chk("dout", DCF_DOUT_CLR, o_dout);
  endtask : mclr

  // ====
  // clock, watchdog, sequence
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  initial begin
    repeat (60000) @(posedge i_clk);
    n_fail++;
    final_report();
  end

  initial begin
    {i_rst_n, wr_go, rd_go, i_fallthrough_serial_in, i_din, i_out_drive_en_n} = '0;
    {i_master_clear_n, i_partial_clear_n, i_wr_en_n, i_rd_en_n} = '1;
    {i_replay_n, i_offset_access_n, i_ser_load_en_n} = '1;
    n_fail = 0;
    samples_checked = 0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    mclr(1'b0, 1'b1);
    port(0, 1, 1, 0, 1, 0);
    chk("ofs", DCF_DW'(DCF_OFS_SER_DEF), o_dout);
    foreach (rows[i]) port(1, 0, 0, 1, 1, 1, rows[i][2*DCF_DW-1:DCF_DW]);
    port(0, 1, 1, 1, 1, 1);
    chf("empty_n", 1'b0, o_empty_valid_n);
    port(0, 1, 1, 1, 1, 1);
    chf("empty_n", 1'b1, o_empty_valid_n);
    port(0, 1, 1, 0, 1, 1);
    chk("dout", rows[0][DCF_DW-1:0], o_dout);
    port(0, 0, 1, 1, 1, 1);
    port(0, 1, 1, 1, 0, 1);
    chf("empty_n", 1'b0, o_empty_valid_n);
    port(0, 1, 1, 1, 1, 1);
    chf("empty_n", 1'b1, o_empty_valid_n);
    foreach (rows[i]) begin
      port(0, 1, 1, 0, 1, 1);
      chk("dout", rows[i][DCF_DW-1:0], o_dout);
    end
    chf("empty_n", 1'b0, o_empty_valid_n);
    port(1, 1, 1, 0, 1, 1, 18'h12345);
    chk("dout", rows[3][DCF_DW-1:0], o_dout);
    repeat (2) port(0, 1, 1, 1, 1, 1);
    chf("empty_n", 1'b0, o_empty_valid_n);
    @(posedge i_clk);
    i_out_drive_en_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    chf("oe", 1'b0, o_dout_oe);
    @(posedge i_clk);
    i_out_drive_en_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chf("oe", 1'b1, o_dout_oe);
    repeat (4096) port(1, 0, 0, 1, 1, 1, 18'h0ABCD);
    chf("half_n", 1'b1, o_half_full_n);
    port(1, 0, 0, 1, 1, 1, 18'h0ABCD);
    chf("half_n", 1'b0, o_half_full_n);
    repeat (2) port(0, 1, 1, 1, 1, 1);
    chf("empty_n", 1'b1, o_empty_valid_n);
    chf("aempty_n", 1'b1, o_almost_empty_n);
    chf("half_n", 1'b0, o_half_full_n);
    port(0, 1, 1, 0, 1, 1);
    chf("half_n", 1'b1, o_half_full_n);
    repeat (4096) port(1, 0, 0, 1, 1, 1, 18'h0ABCD);
    chf("full_n", 1'b0, o_full_space_n);
    chf("afull_n", 1'b0, o_almost_full_n);
    port(0, 1, 1, 0, 1, 1);
    port(1, 0, 1, 1, 1, 1);
    chf("full_n", 1'b0, o_full_space_n);
    port(1, 0, 1, 1, 1, 1);
    chf("full_n", 1'b1, o_full_space_n);
    i_ser_load_en_n <= 1'b0;
    for (int i = 0; i < 2 * DCF_OW; i++) begin
      i_fallthrough_serial_in <= SER_WORD[i];
      port(1, 0, 1, 1, 1, 0);
    end
    i_ser_load_en_n <= 1'b1;
    port(0, 1, 1, 0, 1, 0);
    chk("ofs", DCF_DW'(SER_WORD[2*DCF_OW-1:DCF_OW]), o_dout);
    port(0, 1, 1, 0, 1, 0);
    chk("ofs", DCF_DW'(SER_WORD[DCF_OW-1:0]), o_dout);
    // ====
    // fall-through mode, parallel method
    mclr(1'b1, 1'b0);
    port(0, 1, 1, 0, 1, 0);
    chk("ofs", DCF_DW'(DCF_OFS_PAR_DEF), o_dout);
    port(1, 0, 0, 1, 1, 0, 18'h00011);
    port(1, 0, 0, 1, 1, 0, 18'h00022);
    port(1, 0, 0, 1, 1, 1, 18'h2468A);
    repeat (2) port(0, 1, 1, 1, 1, 1);
    chf("valid_n", 1'b1, o_empty_valid_n);
    port(0, 1, 1, 1, 1, 1);
    chk("dout", 18'h2468A, o_dout);
    chf("valid_n", 1'b0, o_empty_valid_n);
    port(0, 1, 1, 0, 1, 1);
    chf("valid_n", 1'b1, o_empty_valid_n);
    chk("dout", 18'h2468A, o_dout);
    port(0, 1, 1, 0, 1, 0);
    chk("ofs", 18'h00022, o_dout);
    port(0, 0, 1, 1, 1, 1);
    port(0, 1, 1, 1, 0, 1);
    chf("valid_n", 1'b1, o_empty_valid_n);
    repeat (2) port(0, 1, 1, 1, 1, 1);
    chf("valid_n", 1'b0, o_empty_valid_n);
    chk("dout", 18'h2468A, o_dout);
    @(posedge i_clk);
    i_partial_clear_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_partial_clear_n <= 1'b1;
    #1;
    chk("dout", DCF_DOUT_CLR, o_dout);
    chk("flags", 18'h0000D, DCF_DW'(flags));
    port(0, 1, 1, 0, 1, 0);
    chk("ofs", 18'h00011, o_dout);
    final_report();
  end
endmodule : dcf_fifo_ctrl_tb

`default_nettype wire
